// ===== logic/rf_top.sv
// General register file with on-chip local frame cache and load scoreboard.
// Functional notes
// - Sixteen 32-bit globals and four 80-bit extended globals are held, twenty in all.
// - Globals and extended registers are never swapped by a call or return; only global 15, the frame pointer, moves on a spill or refill.
// - Each call gets a fresh frame of sixteen 32-bit locals, indexed 0 to 15.
// - Up to four local frames live on chip, so three nested calls need no stack traffic.
// - A call with four frames on chip first writes the oldest frame to the memory stack.
// - Global 15 is the frame pointer that addresses the memory stack of spilled frames.
// - Any general register, global or local, may be a floating-point operand or result.
// - Starting a load sets the busy scoreboard bit of its destination register.
// - The busy bit clears in the cycle the returning load data is written to the register.
// - An instruction reading a busy register stalls until its bit is clear.
// - An ALU instruction touching no busy register issues without waiting for loads; calls and returns wait for every load.
// - At most three loads are outstanding; a fourth stalls until one completes.
`timescale 1ns/1ps
module rf_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic iss_valid,
    input wire rf_pkg::rf_op_e iss_op,
    input wire logic iss_src_a_en,
    input wire logic [rf_pkg::RF_IDX_W-1:0] iss_src_a,
    input wire logic iss_src_b_en,
    input wire logic [rf_pkg::RF_IDX_W-1:0] iss_src_b,
    input wire logic iss_dst_en,
    input wire logic [rf_pkg::RF_IDX_W-1:0] iss_dst,
    input wire logic [rf_pkg::RF_W-1:0] iss_wdata,
    input wire logic [1:0] iss_ext_ridx,
    input wire logic iss_ext_we,
    input wire logic [1:0] iss_ext_widx,
    input wire logic [rf_pkg::RF_EXT_W-1:0] iss_ext_wdata,
    output logic iss_done,
    output logic [rf_pkg::RF_W-1:0] rd_a_data,
    output logic [rf_pkg::RF_W-1:0] rd_b_data,
    output logic [rf_pkg::RF_EXT_W-1:0] ext_rd_data,
    output logic ld_req,
    output logic [rf_pkg::RF_TAG_W-1:0] ld_tag,
    input wire logic ld_rsp_valid,
    input wire logic [rf_pkg::RF_TAG_W-1:0] ld_rsp_tag,
    input wire logic [rf_pkg::RF_W-1:0] ld_rsp_data,
    output logic mem_req,
    output logic mem_we,
    output logic [rf_pkg::RF_W-1:0] mem_addr,
    output logic [rf_pkg::RF_W-1:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [rf_pkg::RF_W-1:0] mem_rdata,
    output logic [31:0] sb_busy
);
    typedef struct packed {
        rf_pkg::rf_st_e st;
        logic [rf_pkg::RF_NUM_GL-1:0][rf_pkg::RF_W-1:0] gl;
        logic [rf_pkg::RF_NUM_EXT-1:0][rf_pkg::RF_EXT_W-1:0] ext;
        logic [rf_pkg::RF_NUM_FR-1:0][rf_pkg::RF_NUM_LOC-1:0][rf_pkg::RF_W-1:0] fr;
        logic [1:0] cur;
        logic [2:0] onchip;
        logic [rf_pkg::RF_DEPTH_W-1:0] depth;
        logic [3:0] cnt;
        logic [31:0] sb;
        logic done;
        logic [rf_pkg::RF_W-1:0] rd_a;
        logic [rf_pkg::RF_W-1:0] rd_b;
        logic [rf_pkg::RF_EXT_W-1:0] ext_rd;
        logic ld_req;
        logic [rf_pkg::RF_TAG_W-1:0] ld_tag;
        logic mem_req;
        logic mem_we;
        logic [rf_pkg::RF_W-1:0] mem_addr;
        logic [rf_pkg::RF_W-1:0] mem_wdata;
    } rf_state_s;

    rf_state_s state_reg;
    rf_state_s state_next;

    logic a_busy;
    logic b_busy;
    logic d_busy;
    logic hz;
    logic acc;
    logic free_ok;
    logic [rf_pkg::RF_TAG_W-1:0] free_idx;
    logic [rf_pkg::RF_NUM_LD-1:0] slot_set;
    logic [rf_pkg::RF_NUM_LD-1:0] slot_clr;
    logic [rf_pkg::RF_NUM_LD-1:0] slot_busy;
    logic [rf_pkg::RF_NUM_LD-1:0][rf_pkg::RF_IDX_W-1:0] slot_dst;
    logic rsp_ok;
    logic [rf_pkg::RF_IDX_W-1:0] rsp_dst;
    logic [1:0] old_slot;

    rf_sb_check u_chk_a (.sb(state_reg.sb), .en(iss_src_a_en), .idx(iss_src_a), .hit(a_busy));
    rf_sb_check u_chk_b (.sb(state_reg.sb), .en(iss_src_b_en), .idx(iss_src_b), .hit(b_busy));
    rf_sb_check u_chk_d (.sb(state_reg.sb), .en(iss_dst_en), .idx(iss_dst), .hit(d_busy));

    for (genvar g = 0; g < rf_pkg::RF_NUM_LD; g++) begin : g_slot
        rf_ld_slot u_slot (
            .sys_clk(sys_clk),
            .reset(reset),
            .set(slot_set[g]),
            .clr(slot_clr[g]),
            .set_dst(iss_dst),
            .busy(slot_busy[g]),
            .dst(slot_dst[g])
        );
    end

    always_comb begin
        free_ok = 1'b0;
        free_idx = '0;
        for (int i = rf_pkg::RF_NUM_LD - 1; i >= 0; i--) begin
            if (!slot_busy[i]) begin
                free_ok = 1'b1;
                free_idx = rf_pkg::RF_TAG_W'(i);
            end
        end
    end

    assign rsp_ok = ld_rsp_valid && slot_busy[ld_rsp_tag];
    assign rsp_dst = slot_dst[ld_rsp_tag];
    assign old_slot = state_reg.cur + 2'h1;
    // Frame moves wait for an empty scoreboard, so a load never lands in a moved frame.
    assign hz = a_busy || b_busy || d_busy
        || (iss_op == rf_pkg::RF_OP_LOAD && (!free_ok || !iss_dst_en))
        || ((iss_op == rf_pkg::RF_OP_CALL || iss_op == rf_pkg::RF_OP_RET) && (|state_reg.sb));
    assign acc = iss_valid && !state_reg.done && state_reg.st == rf_pkg::RF_ST_RUN && !hz;

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.ld_req = 1'b0;
        slot_set = '0;
        slot_clr = '0;
        if (rsp_ok) begin
            slot_clr[ld_rsp_tag] = 1'b1;
            state_next.sb[rsp_dst] = 1'b0;
            if (rsp_dst[rf_pkg::RF_GLOBAL_BIT]) begin
                state_next.gl[rsp_dst[3:0]] = ld_rsp_data;
            end else begin
                state_next.fr[state_reg.cur][rsp_dst[3:0]] = ld_rsp_data;
            end
        end
        case (state_reg.st)
            rf_pkg::RF_ST_RUN: begin
                if (acc) begin
                    state_next.done = 1'b1;
                    // Any general register feeds the floating-point unit as well.
                    state_next.rd_a = iss_src_a[rf_pkg::RF_GLOBAL_BIT] ? state_reg.gl[iss_src_a[3:0]]
                        : state_reg.fr[state_reg.cur][iss_src_a[3:0]];
                    state_next.rd_b = iss_src_b[rf_pkg::RF_GLOBAL_BIT] ? state_reg.gl[iss_src_b[3:0]]
                        : state_reg.fr[state_reg.cur][iss_src_b[3:0]];
                    state_next.ext_rd = state_reg.ext[iss_ext_ridx];
                    case (iss_op)
                        rf_pkg::RF_OP_ALU: begin
                            if (iss_dst_en && iss_dst[rf_pkg::RF_GLOBAL_BIT]) begin
                                state_next.gl[iss_dst[3:0]] = iss_wdata;
                            end else if (iss_dst_en) begin
                                state_next.fr[state_reg.cur][iss_dst[3:0]] = iss_wdata;
                            end
                            if (iss_ext_we) begin
                                state_next.ext[iss_ext_widx] = iss_ext_wdata;
                            end
                        end
                        rf_pkg::RF_OP_LOAD: begin
                            slot_set[free_idx] = 1'b1;
                            state_next.sb[iss_dst] = 1'b1;
                            state_next.ld_req = 1'b1;
                            state_next.ld_tag = free_idx;
                        end
                        rf_pkg::RF_OP_CALL: begin
                            if (state_reg.onchip == rf_pkg::RF_FR_FULL) begin
                                state_next.st = rf_pkg::RF_ST_SPILL;
                                state_next.cnt = '0;
                                state_next.mem_req = 1'b1;
                                state_next.mem_we = 1'b1;
                                state_next.mem_addr = state_reg.gl[rf_pkg::RF_FP_IDX];
                                state_next.mem_wdata = state_reg.fr[old_slot][0];
                            end else begin
                                state_next.cur = state_reg.cur + 2'h1;
                                state_next.fr[state_reg.cur + 2'h1] = '0;
                                state_next.onchip = state_reg.onchip + 3'h1;
                                state_next.depth = state_reg.depth + 16'h1;
                            end
                        end
                        rf_pkg::RF_OP_RET: begin
                            // A return from the outermost frame has no caller and is dropped.
                            if (state_reg.depth != rf_pkg::RF_DEPTH_RST) begin
                                state_next.depth = state_reg.depth - 16'h1;
                                state_next.cur = state_reg.cur - 2'h1;
                                if (state_reg.onchip != rf_pkg::RF_ONCHIP_RST) begin
                                    state_next.onchip = state_reg.onchip - 3'h1;
                                end else begin
                                    state_next.st = rf_pkg::RF_ST_FILL;
                                    state_next.cnt = '0;
                                    state_next.mem_req = 1'b1;
                                    state_next.mem_we = 1'b0;
                                    state_next.mem_addr = state_reg.gl[rf_pkg::RF_FP_IDX] - rf_pkg::RF_FRAME_BYTES;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            rf_pkg::RF_ST_SPILL: begin
                if (mem_ack) begin
                    if (state_reg.cnt == rf_pkg::RF_LAST_WORD) begin
                        state_next.st = rf_pkg::RF_ST_RUN;
                        state_next.mem_req = 1'b0;
                        state_next.mem_we = 1'b0;
                        state_next.cur = old_slot;
                        state_next.fr[old_slot] = '0;
                        state_next.depth = state_reg.depth + 16'h1;
                        state_next.gl[rf_pkg::RF_FP_IDX] = state_reg.gl[rf_pkg::RF_FP_IDX]
                            + rf_pkg::RF_FRAME_BYTES;
                    end else begin
                        state_next.cnt = state_reg.cnt + 4'h1;
                        state_next.mem_addr = state_reg.mem_addr + rf_pkg::RF_WORD_BYTES;
                        state_next.mem_wdata = state_reg.fr[old_slot][state_reg.cnt + 4'h1];
                    end
                end
            end
            rf_pkg::RF_ST_FILL: begin
                if (mem_ack) begin
                    state_next.fr[state_reg.cur][state_reg.cnt] = mem_rdata;
                    if (state_reg.cnt == rf_pkg::RF_LAST_WORD) begin
                        state_next.st = rf_pkg::RF_ST_RUN;
                        state_next.mem_req = 1'b0;
                        state_next.gl[rf_pkg::RF_FP_IDX] = state_reg.gl[rf_pkg::RF_FP_IDX]
                            - rf_pkg::RF_FRAME_BYTES;
                    end else begin
                        state_next.cnt = state_reg.cnt + 4'h1;
                        state_next.mem_addr = state_reg.mem_addr + rf_pkg::RF_WORD_BYTES;
                    end
                end
            end
            default: begin
                state_next.st = rf_pkg::RF_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.onchip <= rf_pkg::RF_ONCHIP_RST;
            state_reg.depth <= rf_pkg::RF_DEPTH_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign iss_done = state_reg.done;
    assign rd_a_data = state_reg.rd_a;
    assign rd_b_data = state_reg.rd_b;
    assign ext_rd_data = state_reg.ext_rd;
    assign ld_req = state_reg.ld_req;
    assign ld_tag = state_reg.ld_tag;
    assign mem_req = state_reg.mem_req;
    assign mem_we = state_reg.mem_we;
    assign mem_addr = state_reg.mem_addr;
    assign mem_wdata = state_reg.mem_wdata;
    assign sb_busy = state_reg.sb;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_spill_start;
        state_reg.st == rf_pkg::RF_ST_SPILL && mem_req && mem_we && state_reg.cnt == 4'h0;
    endsequence
    sequence s_fill_start;
        state_reg.st == rf_pkg::RF_ST_FILL && mem_req && !mem_we;
    endsequence

    property p_load_sets_sb;
        acc && iss_op == rf_pkg::RF_OP_LOAD |=> sb_busy[$past(iss_dst)] && ld_req;
    endproperty
    a_load_sets_sb: assert property (p_load_sets_sb) else $error("load did not set busy bit");

    property p_rsp_clears_sb;
        rsp_ok |=> !sb_busy[$past(rsp_dst)];
    endproperty
    a_rsp_clears_sb: assert property (p_rsp_clears_sb) else $error("load return left busy bit");

    property p_read_busy_stalls;
        iss_valid && iss_src_a_en && sb_busy[iss_src_a] && !rsp_ok |=> !iss_done;
    endproperty
    a_read_busy_stalls: assert property (p_read_busy_stalls) else $error("read of busy register issued");

    property p_free_issues;
        iss_valid && !iss_done && state_reg.st == rf_pkg::RF_ST_RUN && iss_op == rf_pkg::RF_OP_ALU
            && !a_busy && !b_busy && !d_busy |=> iss_done;
    endproperty
    a_free_issues: assert property (p_free_issues) else $error("independent instruction waited");

    property p_fourth_load_stalls;
        iss_valid && iss_op == rf_pkg::RF_OP_LOAD && (&slot_busy) |=> !iss_done;
    endproperty
    a_fourth_load_stalls: assert property (p_fourth_load_stalls) else $error("fourth load issued");

    property p_write_busy_stalls;
        iss_valid && d_busy |=> !iss_done;
    endproperty
    a_write_busy_stalls: assert property (p_write_busy_stalls) else $error("write to busy register issued");

    property p_call_keeps_globals;
        acc && iss_op == rf_pkg::RF_OP_CALL && state_reg.onchip != rf_pkg::RF_FR_FULL
            |=> state_reg.gl == $past(state_reg.gl) && state_reg.ext == $past(state_reg.ext) && !mem_req;
    endproperty
    a_call_keeps_globals: assert property (p_call_keeps_globals) else $error("call changed globals");

    property p_call_fresh_frame;
        acc && iss_op == rf_pkg::RF_OP_CALL && state_reg.onchip != rf_pkg::RF_FR_FULL
            |=> state_reg.fr[state_reg.cur] == '0 && state_reg.cur == $past(state_reg.cur) + 2'h1;
    endproperty
    a_call_fresh_frame: assert property (p_call_fresh_frame) else $error("call frame not fresh");

    property p_full_call_spills;
        acc && iss_op == rf_pkg::RF_OP_CALL && state_reg.onchip == rf_pkg::RF_FR_FULL
            |=> s_spill_start ##0 mem_addr == $past(state_reg.gl[rf_pkg::RF_FP_IDX]);
    endproperty
    a_full_call_spills: assert property (p_full_call_spills) else $error("full call did not spill");

    property p_ret_refills;
        acc && iss_op == rf_pkg::RF_OP_RET && state_reg.onchip == rf_pkg::RF_ONCHIP_RST
            && state_reg.depth != rf_pkg::RF_DEPTH_RST |=> s_fill_start ##1 !iss_done;
    endproperty
    a_ret_refills: assert property (p_ret_refills) else $error("return did not refill frame");
endmodule : rf_top

// ===== logic/rf_pkg.sv
// Constants and types shared by the register file, frame cache and scoreboard.
package rf_pkg;
    localparam int RF_W = 32;
    localparam int RF_EXT_W = 80;
    localparam int RF_NUM_GL = 16;
    localparam int RF_NUM_EXT = 4;
    localparam int RF_NUM_LOC = 16;
    localparam int RF_NUM_FR = 4;
    localparam int RF_NUM_LD = 3;
    localparam int RF_IDX_W = 5;
    localparam int RF_TAG_W = 2;
    localparam int RF_DEPTH_W = 16;
    localparam int RF_GLOBAL_BIT = 4;
    localparam logic [3:0] RF_FP_IDX = 4'hf;
    localparam logic [3:0] RF_LAST_WORD = 4'hf;
    localparam logic [31:0] RF_FRAME_BYTES = 32'h40;
    localparam logic [31:0] RF_WORD_BYTES = 32'h4;
    localparam logic [2:0] RF_FR_FULL = 3'h4;
    localparam logic [2:0] RF_ONCHIP_RST = 3'h1;
    localparam logic [15:0] RF_DEPTH_RST = 16'h1;

    typedef enum logic [1:0] {RF_OP_ALU, RF_OP_LOAD, RF_OP_CALL, RF_OP_RET} rf_op_e;
    typedef enum logic [1:0] {RF_ST_RUN, RF_ST_SPILL, RF_ST_FILL} rf_st_e;
endpackage : rf_pkg

// ===== logic/rf_sb_check.sv
// Scoreboard lookup for one register reference.
`timescale 1ns/1ps
module rf_sb_check (
    input wire logic [31:0] sb,
    input wire logic en,
    input wire logic [rf_pkg::RF_IDX_W-1:0] idx,
    output logic hit
);
    assign hit = en & sb[idx];
endmodule : rf_sb_check

// ===== logic/rf_ld_slot.sv
// One outstanding load slot: busy flag and destination register.
`timescale 1ns/1ps
module rf_ld_slot (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic set,
    input wire logic clr,
    input wire logic [rf_pkg::RF_IDX_W-1:0] set_dst,
    output logic busy,
    output logic [rf_pkg::RF_IDX_W-1:0] dst
);
    typedef struct packed {
        logic busy;
        logic [rf_pkg::RF_IDX_W-1:0] dst;
    } rf_slot_s;

    rf_slot_s slot_reg;
    rf_slot_s slot_next;

    always_comb begin
        slot_next = slot_reg;
        if (clr) begin
            slot_next.busy = 1'b0;
        end
        // Should set and clr meet, set wins; rf_top only sets a slot whose busy flag is already clear.
        if (set) begin
            slot_next.busy = 1'b1;
            slot_next.dst = set_dst;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            slot_reg <= '0;
        end else begin
            slot_reg <= slot_next;
        end
    end

    assign busy = slot_reg.busy;
    assign dst = slot_reg.dst;
endmodule : rf_ld_slot

// ===== dv/rf_far_model.sv
// Load unit and memory stack model facing the register file.
`timescale 1ns/1ps
module rf_far_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic ld_req,
    input wire logic [rf_pkg::RF_TAG_W-1:0] ld_tag,
    output logic ld_rsp_valid = 1'b0,
    output logic [rf_pkg::RF_TAG_W-1:0] ld_rsp_tag = 2'h0,
    output logic [rf_pkg::RF_W-1:0] ld_rsp_data = 32'h0,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [rf_pkg::RF_W-1:0] mem_addr,
    input wire logic [rf_pkg::RF_W-1:0] mem_wdata,
    output logic mem_ack = 1'b0,
    output logic [rf_pkg::RF_W-1:0] mem_rdata = 32'h0
);
    logic [31:0] stk [logic [31:0]];
    int due_q[$];
    logic [1:0] tag_q[$];
    int cyc = 0;
    int cnt = 0;
    logic [31:0] seq = 32'h0;
    // Returns come back in issue order, so the n-th load always carries data base plus n.
    always @(posedge sys_clk) begin
        cyc++;
        ld_rsp_valid <= 1'b0;
        ld_rsp_data <= ~ld_rsp_data;
        if (reset) begin
            due_q.delete();
            tag_q.delete();
            seq = 32'h0;
            mem_ack <= 1'b0;
            cnt = 0;
        end else begin
            if (ld_req) begin
                due_q.push_back(cyc + (slow ? 30 : 2));
                tag_q.push_back(ld_tag);
            end
            if (due_q.size() > 0 && due_q[0] <= cyc) begin
                void'(due_q.pop_front());
                ld_rsp_valid <= 1'b1;
                ld_rsp_tag <= tag_q.pop_front();
                ld_rsp_data <= 32'h1d00_0000 + seq;
                seq = seq + 32'h1;
            end
            if (mem_ack) begin
                mem_ack <= 1'b0;
                mem_rdata <= ~mem_rdata;
                cnt = 0;
            end else if (mem_req) begin
                if (cnt >= (slow ? 3 : 0)) begin
                    mem_ack <= 1'b1;
                    if (mem_we) begin
                        stk[mem_addr] = mem_wdata;
                    end else begin
                        mem_rdata <= stk.exists(mem_addr) ? stk[mem_addr] : ~mem_rdata;
                    end
                    cnt = 0;
                end else begin
                    cnt++;
                end
            end
        end
    end
endmodule : rf_far_model

// ===== dv/testbench.sv
// Self-checking bench for the register file, frame cache and load scoreboard.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    typedef struct packed {logic chk; logic [31:0] a; logic [31:0] b; logic [79:0] e;} rf_note_s;
    localparam rf_pkg::rf_op_e ALU = rf_pkg::RF_OP_ALU;
    localparam rf_pkg::rf_op_e LD = rf_pkg::RF_OP_LOAD;
    localparam rf_pkg::rf_op_e CALL = rf_pkg::RF_OP_CALL;
    localparam rf_pkg::rf_op_e RET = rf_pkg::RF_OP_RET;
    localparam logic [5:0] N = 6'h00;
    logic sys_clk, reset, iss_valid, iss_src_a_en, iss_src_b_en, iss_dst_en, iss_ext_we, iss_done, slow;
    rf_pkg::rf_op_e iss_op;
    logic [4:0] iss_src_a, iss_src_b, iss_dst;
    logic [31:0] iss_wdata, rd_a_data, rd_b_data, ld_rsp_data, mem_addr, mem_wdata, mem_rdata, sb_busy;
    logic [1:0] iss_ext_ridx, iss_ext_widx, ld_tag, ld_rsp_tag, x_ridx, x_widx;
    logic [79:0] iss_ext_wdata, ext_rd_data, x_wd;
    logic [79:0] ext_m [4];
    logic ld_req, ld_rsp_valid, mem_req, mem_we, mem_ack, x_we;
    logic [31:0] seed, v, v2, g2, wr0, rd0;
    logic [31:0] fv [5];
    rf_note_s notes[$];
    rf_note_s cur;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, n_wr = 0, n_rd = 0, w, k;
    rf_top rf_top_inst (.sys_clk(sys_clk), .reset(reset), .iss_valid(iss_valid), .iss_op(iss_op),
        .iss_src_a_en(iss_src_a_en), .iss_src_a(iss_src_a), .iss_src_b_en(iss_src_b_en), .iss_src_b(iss_src_b),
        .iss_dst_en(iss_dst_en), .iss_dst(iss_dst), .iss_wdata(iss_wdata), .iss_ext_ridx(iss_ext_ridx),
        .iss_ext_we(iss_ext_we), .iss_ext_widx(iss_ext_widx), .iss_ext_wdata(iss_ext_wdata), .iss_done(iss_done),
        .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .ext_rd_data(ext_rd_data), .ld_req(ld_req), .ld_tag(ld_tag),
        .ld_rsp_valid(ld_rsp_valid), .ld_rsp_tag(ld_rsp_tag), .ld_rsp_data(ld_rsp_data), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .sb_busy(sb_busy));
    rf_far_model rf_far_model_inst (.sys_clk(sys_clk), .reset(reset), .slow(slow), .ld_req(ld_req),
        .ld_tag(ld_tag), .ld_rsp_valid(ld_rsp_valid), .ld_rsp_tag(ld_rsp_tag), .ld_rsp_data(ld_rsp_data),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    function automatic logic [5:0] gr(input int i);
        return {2'b11, 4'(i)};
    endfunction : gr
    function automatic logic [5:0] lr(input int i);
        return {2'b10, 4'(i)};
    endfunction : lr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // Notes the expected read data, then holds the request until it is taken or 300 cycles pass; w counts the wait.
    task automatic issue(input rf_pkg::rf_op_e op, input logic [5:0] a, input logic [5:0] b, input logic [5:0] d,
                         input logic [31:0] wd, input logic chk, input logic [31:0] ea, input logic [31:0] eb,
                         output int w);
        @(negedge sys_clk);
        iss_valid = 1'b1;
        iss_op = op;
        {iss_src_a_en, iss_src_a} = a;
        {iss_src_b_en, iss_src_b} = b;
        {iss_dst_en, iss_dst} = d;
        iss_wdata = wd;
        {iss_ext_we, iss_ext_widx, iss_ext_wdata, iss_ext_ridx} = {x_we, x_widx, x_wd, x_ridx};
        notes.push_back('{chk, ea, eb, ext_m[x_ridx]});
        if (x_we) begin
            ext_m[x_widx] = x_wd;
        end
        x_we = 1'b0;
        w = 0;
        do begin
            @(negedge sys_clk);
            w++;
        end while (iss_done !== 1'b1 && w < 300);
        // A request that is never taken would leave its note behind, so it counts as a fault here.
        if (iss_done !== 1'b1) n_mismatch++;
        iss_valid = 1'b0;
        iss_ext_we = 1'b0;
        if (op == LD) begin
            `CHK(ld_req, 1'b1)
            `CHK(sb_busy[iss_dst], 1'b1)
        end
    endtask : issue
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (!reset && iss_done === 1'b1) begin
            cur = notes.pop_front();
            if (cur.chk) begin
                `CHK(rd_a_data, cur.a)
                `CHK(rd_b_data, cur.b)
                `CHK(ext_rd_data, cur.e)
            end
        end
    end
    // Stack traffic is counted here so spill and refill can be judged without peeking inside.
    always @(posedge sys_clk) begin
        cyc++;
        if (mem_req && mem_ack) begin
            if (mem_we) begin
                if (n_wr == 0) wr0 = mem_addr;
                n_wr++;
            end else begin
                if (n_rd == 0) rd0 = mem_addr;
                n_rd++;
            end
        end
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    initial begin
        seed = 32'h4a09;
        reset = 1'b1;
        {iss_valid, iss_src_a_en, iss_src_b_en, iss_dst_en, iss_ext_we, x_we, slow} = 7'h0;
        iss_op = ALU;
        {iss_src_a, iss_src_b, iss_dst, iss_wdata, iss_ext_ridx, iss_ext_widx, x_ridx, x_widx} = 55'h0;
        {iss_ext_wdata, x_wd} = 160'h0;
        for (k = 0; k < 4; k++) ext_m[k] = 80'h0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        slow = 1'b1;
        v = $random(seed);
        issue(LD, N, N, lr(4), 32'h0, 1'b0, 32'h0, 32'h0, w);
        issue(LD, N, N, lr(5), 32'h0, 1'b0, 32'h0, 32'h0, w);
        issue(LD, N, N, gr(3), 32'h0, 1'b0, 32'h0, 32'h0, w);
        issue(ALU, gr(1), gr(2), gr(7), v, 1'b1, 32'h0, 32'h0, w);
        `CHK(w == 1, 1'b1)
        issue(LD, N, N, lr(6), 32'h0, 1'b0, 32'h0, 32'h0, w);
        `CHK(w > 1, 1'b1)
        v2 = $random(seed);
        issue(ALU, N, N, gr(3), v2, 1'b0, 32'h0, 32'h0, w);
        `CHK(w > 1, 1'b1)
        issue(ALU, lr(4), lr(6), N, 32'h0, 1'b1, 32'h1d00_0000, 32'h1d00_0003, w);
        `CHK(w > 1, 1'b1)
        issue(ALU, gr(3), lr(5), N, 32'h0, 1'b1, v2, 32'h1d00_0001, w);
        `CHK(sb_busy, 32'h0)
        g2 = $random(seed);
        for (k = 0; k < 5; k++) fv[k] = $random(seed);
        issue(ALU, gr(7), N, gr(15), 32'h1000, 1'b1, v, 32'h0, w);
        issue(ALU, N, N, gr(2), g2, 1'b0, 32'h0, 32'h0, w);
        issue(ALU, N, N, lr(1), fv[0], 1'b0, 32'h0, 32'h0, w);
        for (k = 0; k < 4; k++) begin
            {x_we, x_widx, x_ridx} = {1'b1, 2'(k), 2'(k + 1)};
            x_wd = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
            issue(ALU, gr(15), gr(2), N, 32'h0, 1'b1, 32'h1000, g2, w);
        end
        n_wr = 0;
        n_rd = 0;
        for (k = 1; k <= 4; k++) begin
            issue(CALL, N, N, N, 32'h0, 1'b0, 32'h0, 32'h0, w);
            if (k == 3) `CHK(n_wr, 0)
            issue(ALU, lr(1), gr(2), N, 32'h0, 1'b1, 32'h0, g2, w);
            issue(ALU, N, N, lr(1), fv[k], 1'b0, 32'h0, 32'h0, w);
        end
        `CHK(n_wr, 16)
        `CHK(wr0, 32'h1000)
        issue(ALU, gr(15), gr(2), N, 32'h0, 1'b1, 32'h1040, g2, w);
        slow = 1'b0;
        for (k = 3; k >= 0; k--) begin
            x_ridx = 2'(k);
            issue(RET, N, N, N, 32'h0, 1'b0, 32'h0, 32'h0, w);
            issue(ALU, lr(1), gr(2), N, 32'h0, 1'b1, fv[k], g2, w);
        end
        `CHK(n_rd, 16)
        `CHK(rd0, 32'h1000)
        issue(ALU, gr(15), gr(2), N, 32'h0, 1'b1, 32'h1000, g2, w);
        issue(RET, N, N, N, 32'h0, 1'b0, 32'h0, 32'h0, w);
        issue(ALU, lr(1), gr(15), N, 32'h0, 1'b1, fv[0], 32'h1000, w);
        `CHK(n_rd, 16)
        issue(LD, N, N, gr(9), 32'h0, 1'b0, 32'h0, 32'h0, w);
        issue(ALU, gr(9), gr(15), N, 32'h0, 1'b1, 32'h1d00_0004, 32'h1000, w);
        `CHK(w > 1, 1'b1)
        repeat (2) @(negedge sys_clk);
        wrap_up;
    end
endmodule : testbench
